// *** shared/rcs_pkg.sv ***
package rcs_pkg;
  // ==========================================================
  // Clock rate and timing
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned INTOSC_US      = 3;      // Internal osc start
  localparam int unsigned XTAL_MS        = 2;      // Crystal start
  localparam int unsigned DEV_PULSE_US   = 600;    // Device-driven pin low
  localparam int unsigned INTOSC_CYC     = INTOSC_US * CLK_MHZ;
  localparam int unsigned XTAL_CYC       = XTAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEV_PULSE_CYC  = DEV_PULSE_US * CLK_MHZ;
  localparam int unsigned EXT_MIN_CYC    = 32;     // Ext pulse minimum
  localparam int unsigned WDOG_CYC       = 512;    // Watchdog pulse
  localparam int unsigned ADDR_VALID_CYC = 32;     // Pin high to valid
  localparam int unsigned LOCK_EDGES     = 2000;   // Ref edges per lock
  localparam int unsigned LOCKS_NEEDED   = 2;
  localparam int unsigned CNT_W          = 18;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PLL_CFG  = 8'h04;
  localparam logic [7:0] ADDR_PLL_STS  = 8'h08;
  localparam logic [7:0] ADDR_BOOT_STS = 8'h0c;
  localparam int unsigned SYSDIV_LSB   = 0;   // 2 bits, ratio 1<<sel
  localparam int unsigned OUTDIV_LSB   = 2;   // 2 bits, 0:/4 1:/2 else /1
  localparam int unsigned OUTEN_BIT    = 4;
  localparam int unsigned MAIN_EN_BIT  = 0;
  localparam int unsigned USB_EN_BIT   = 1;
  localparam logic [1:0] SYSDIV_RST    = 2'h3;  // Divide by eight
  localparam logic [1:0] OUTDIV_RST    = 2'h0;  // Divide by four
  localparam int unsigned BOOT_W       = 4;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rcs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rcs_apb_rsp_t;

  typedef enum logic [4:0] {
    ST_OSC  = 5'b00001,
    ST_HOLD = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_BOOT = 5'b01000,
    ST_RUN  = 5'b10000
  } rcs_state_t;
endpackage

// *** rtl/rcs_sequencer.sv ***
`timescale 1ns/1ps
// Operation
// - Power-up system clock is oscillator clock divided by eight.
// - Clock-out divider resets to zero, dividing system clock by four.
// - With system divide-by-one, clock-out is oscillator clock over four.
// - Clock-out pin stays undriven until firmware enables it.
// - Boot-mode pins are sampled after reset and reported.
// - Reset pin is driven low until io supply crosses threshold.
// - Device-driven reset pin pulse lasts 600 microseconds.
// - Watchdog reset pulse lasts 512 oscillator cycles; the code counts 512 i_clk_sys cycles instead.
// - Address and data valid 32 cycles after reset pin high; at power-up the oscillator start allowance comes in between.
// - Allow 3 microseconds for internal oscillator start.
// - Allow 2 milliseconds for crystal oscillator start.
// - Lock flag sets on the second consecutive lock.
// - Main PLL refs oscillator input; USB PLL refs aux input.
// - Each lock takes 2000 reference clock cycles after config write.
module rcs_sequencer
  import rcs_pkg::*;
#(
  parameter int unsigned DEV_PULSE = rcs_pkg::DEV_PULSE_CYC,
  parameter int unsigned XTAL_WAIT = rcs_pkg::XTAL_CYC
) (
  input  wire logic                  i_clk_sys,       // System clock
  input  wire logic                  i_reset,         // Async reset
  input  wire rcs_pkg::rcs_apb_req_t i_apb,           // APB request
  output rcs_pkg::rcs_apb_rsp_t      o_apb,           // APB response
  input  wire logic                  i_supply_ok,     // Io supply above POR
  input  wire logic                  i_ext_reset_in,  // Reset pin level
  output logic                       o_ext_reset_out, // Reset pin drive
  output logic                       o_ext_reset_oe,  // Reset pin enable
  input  wire logic                  i_watchdog_bite, // Watchdog expiry
  input  wire logic [rcs_pkg::BOOT_W-1:0] i_boot_pins, // Boot straps
  input  wire logic                  i_osc_ref,       // Oscillator input
  input  wire logic                  i_aux_ref,       // Aux clock input
  output logic                       o_sys_reset,     // Internal reset
  output logic                       o_addr_valid,    // Addr/data valid
  output logic [rcs_pkg::BOOT_W-1:0] o_boot_mode,     // Sampled straps
  output logic                       o_boot_valid,    // Straps captured
  output logic                       o_clk_out,       // Clock-out level
  output logic                       o_clk_out_oe     // Clock-out enable
);
  import rcs_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [1:0] sup_sync_q, ext_sync_q, osc_sync_q, aux_sync_q;
  logic [BOOT_W-1:0] boot_m_q, boot_s_q;
  logic osc_prev_q, aux_prev_q;
  logic supply_s, ext_low_s, osc_rise, aux_rise;

  // Two flops per pin, edge detect on the second only
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sup_sync_q <= 2'h0;
      ext_sync_q <= 2'h3;
      osc_sync_q <= 2'h0;
      aux_sync_q <= 2'h0;
      boot_m_q   <= '0;
      boot_s_q   <= '0;
      osc_prev_q <= 1'b0;
      aux_prev_q <= 1'b0;
    end else begin
      sup_sync_q <= {sup_sync_q[0], i_supply_ok};
      ext_sync_q <= {ext_sync_q[0], i_ext_reset_in};
      osc_sync_q <= {osc_sync_q[0], i_osc_ref};
      aux_sync_q <= {aux_sync_q[0], i_aux_ref};
      boot_m_q   <= i_boot_pins;
      boot_s_q   <= boot_m_q;
      osc_prev_q <= osc_sync_q[1];
      aux_prev_q <= aux_sync_q[1];
    end
  end

  assign supply_s  = sup_sync_q[1];
  assign ext_low_s = ~ext_sync_q[1];
  assign osc_rise  = osc_sync_q[1] & ~osc_prev_q;
  assign aux_rise  = aux_sync_q[1] & ~aux_prev_q;

  // ==========================================================
  // Reset sources
  logic [CNT_W-1:0] drv_cnt_q, ext_cnt_q, wd_cnt_q;
  logic             ext_rec_q, wd_act_q;

  // Pin held low under POR, then for the device pulse
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_ext_reset_oe  <= 1'b1;
      o_ext_reset_out <= 1'b0;
      drv_cnt_q       <= '0;
    end else if (!supply_s) begin
      o_ext_reset_oe <= 1'b1;
      drv_cnt_q      <= '0;
    end else if (o_ext_reset_oe) begin
      if (drv_cnt_q == CNT_W'(DEV_PULSE - 1)) begin
        o_ext_reset_oe <= 1'b0;
      end
      drv_cnt_q <= drv_cnt_q + 1'b1;
    end
  end

  // External pulse flagged after minimum low width; internal reset follows any pin low at once
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ext_cnt_q <= '0;
      ext_rec_q <= 1'b0;
    end else if (ext_low_s && !o_ext_reset_oe) begin
      if (ext_cnt_q == CNT_W'(EXT_MIN_CYC - 1)) begin
        ext_rec_q <= 1'b1;
      end else begin
        ext_cnt_q <= ext_cnt_q + 1'b1;
      end
    end else if (!ext_low_s) begin
      ext_cnt_q <= '0;
      ext_rec_q <= 1'b0;
    end
  end

  // Watchdog pulse of fixed width
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wd_act_q <= 1'b0;
      wd_cnt_q <= '0;
    end else if (wd_act_q) begin
      if (wd_cnt_q == CNT_W'(WDOG_CYC - 1)) begin
        wd_act_q <= 1'b0;
      end
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end else if (i_watchdog_bite) begin
      wd_act_q <= 1'b1;
      wd_cnt_q <= '0;
    end
  end

  // ==========================================================
  // Start-up sequencer
  rcs_state_t       state_q;
  logic [CNT_W-1:0] seq_cnt_q;
  logic             any_src;

  assign any_src = ~supply_s | o_ext_reset_oe | ext_low_s | wd_act_q;

  // Oscillator start, pin hold, release delay, strap sample
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q      <= ST_OSC;
      seq_cnt_q    <= '0;
      o_sys_reset  <= 1'b1;
      o_addr_valid <= 1'b0;
      o_boot_mode  <= '0;
      o_boot_valid <= 1'b0;
    end else if (any_src) begin
      o_sys_reset  <= 1'b1;
      o_addr_valid <= 1'b0;
      o_boot_valid <= 1'b0;
      seq_cnt_q    <= '0;
      state_q      <= supply_s ? ST_HOLD : ST_OSC;
      if (state_q == ST_OSC && supply_s) begin
        state_q <= ST_OSC;
      end
    end else begin
      case (state_q)
        ST_OSC: begin
          // Internal osc then crystal start allowance
          if (seq_cnt_q == CNT_W'(INTOSC_CYC + XTAL_WAIT - 1)) begin
            seq_cnt_q <= '0;
            state_q   <= ST_WAIT;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        ST_HOLD: begin
          seq_cnt_q <= '0;
          state_q   <= ST_WAIT;
        end
        ST_WAIT: begin
          if (seq_cnt_q == CNT_W'(ADDR_VALID_CYC - 1)) begin
            o_addr_valid <= 1'b1;
            o_sys_reset  <= 1'b0;
            state_q      <= ST_BOOT;
          end else begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
          end
        end
        ST_BOOT: begin
          o_boot_mode  <= boot_s_q;
          o_boot_valid <= 1'b1;
          state_q      <= ST_RUN;
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_OSC;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers and APB slave
  logic [1:0] sysdiv_q, outdiv_q;
  logic       outen_q, main_en_q, usb_en_q;
  logic       acc_wr, setup;

  assign setup  = i_apb.psel & ~i_apb.penable & ~o_apb.pready;
  assign acc_wr = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite;

  // Clock and PLL control, back to defaults on power-up
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sysdiv_q  <= SYSDIV_RST;
      outdiv_q  <= OUTDIV_RST;
      outen_q   <= 1'b0;
      main_en_q <= 1'b0;
      usb_en_q  <= 1'b0;
    end else if (!supply_s) begin
      sysdiv_q  <= SYSDIV_RST;
      outdiv_q  <= OUTDIV_RST;
      outen_q   <= 1'b0;
      main_en_q <= 1'b0;
      usb_en_q  <= 1'b0;
    end else if (acc_wr && i_apb.paddr == ADDR_CLK_CTRL) begin
      sysdiv_q <= i_apb.pwdata[SYSDIV_LSB +: 2];
      outdiv_q <= i_apb.pwdata[OUTDIV_LSB +: 2];
      outen_q  <= i_apb.pwdata[OUTEN_BIT];
    end else if (acc_wr && i_apb.paddr == ADDR_PLL_CFG) begin
      main_en_q <= i_apb.pwdata[MAIN_EN_BIT];
      usb_en_q  <= i_apb.pwdata[USB_EN_BIT];
    end
  end

  // ==========================================================
  // PLL lock timers
  logic [10:0] main_edge_q, usb_edge_q;
  logic        main_busy_q, usb_busy_q;
  logic [1:0]  main_locks_q, usb_locks_q;
  logic        main_flag_q, usb_flag_q;
  logic        cfg_wr;

  assign cfg_wr = acc_wr && i_apb.paddr == ADDR_PLL_CFG;

  // Main PLL: each config write with the main enable bit set relocks from the oscillator input; a write with it clear drops the lock
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      main_edge_q  <= '0;
      main_busy_q  <= 1'b0;
      main_locks_q <= 2'h0;
      main_flag_q  <= 1'b0;
    end else if (cfg_wr && !i_apb.pwdata[MAIN_EN_BIT]) begin
      main_busy_q  <= 1'b0;
      main_locks_q <= 2'h0;
      main_flag_q  <= 1'b0;
    end else if (cfg_wr) begin
      main_busy_q <= 1'b1;
      main_edge_q <= '0;
    end else if (main_busy_q && osc_rise) begin
      if (main_edge_q == 11'(LOCK_EDGES - 1)) begin
        main_busy_q <= 1'b0;
        if (main_locks_q == 2'(LOCKS_NEEDED - 1)) begin
          main_flag_q <= 1'b1;
        end else begin
          main_locks_q <= main_locks_q + 2'h1;
        end
      end else begin
        main_edge_q <= main_edge_q + 11'h1;
      end
    end
  end

  // USB PLL: same timing, aux clock reference
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      usb_edge_q  <= '0;
      usb_busy_q  <= 1'b0;
      usb_locks_q <= 2'h0;
      usb_flag_q  <= 1'b0;
    end else if (cfg_wr && !i_apb.pwdata[USB_EN_BIT]) begin
      usb_busy_q  <= 1'b0;
      usb_locks_q <= 2'h0;
      usb_flag_q  <= 1'b0;
    end else if (cfg_wr) begin
      usb_busy_q <= 1'b1;
      usb_edge_q <= '0;
    end else if (usb_busy_q && aux_rise) begin
      if (usb_edge_q == 11'(LOCK_EDGES - 1)) begin
        usb_busy_q <= 1'b0;
        if (usb_locks_q == 2'(LOCKS_NEEDED - 1)) begin
          usb_flag_q <= 1'b1;
        end else begin
          usb_locks_q <= usb_locks_q + 2'h1;
        end
      end else begin
        usb_edge_q <= usb_edge_q + 11'h1;
      end
    end
  end

  // Read data and zero-wait-state answer
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_apb <= '0;
    end else begin
      o_apb.pready <= setup;
      if (setup) begin
        o_apb.pslverr <= 1'b0;
        case (i_apb.paddr)
          ADDR_CLK_CTRL: o_apb.prdata <= {27'h0, outen_q, outdiv_q, sysdiv_q};
          ADDR_PLL_CFG:  o_apb.prdata <= {30'h0, usb_en_q, main_en_q};
          ADDR_PLL_STS:  o_apb.prdata <= {26'h0, usb_locks_q, main_locks_q,
                                          usb_flag_q, main_flag_q};
          ADDR_BOOT_STS: o_apb.prdata <= {27'h0, o_boot_valid, o_boot_mode};
          default: begin
            o_apb.prdata  <= 32'h0;
            o_apb.pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Clock-out divider
  logic [4:0] sys_ratio;
  logic [2:0] out_ratio;
  logic [6:0] total;
  logic [5:0] half;
  logic [5:0] co_cnt_q;

  assign sys_ratio = 5'(5'h1 << sysdiv_q);
  assign out_ratio = (outdiv_q == 2'h0) ? 3'h4 :
                     (outdiv_q == 2'h1) ? 3'h2 : 3'h1;
  assign total     = 7'(sys_ratio * out_ratio);
  assign half      = (total < 7'h2) ? 6'h1 : total[6:1];

  // Toggle every half period; pin enabled only by firmware
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      co_cnt_q     <= '0;
      o_clk_out    <= 1'b0;
      o_clk_out_oe <= 1'b0;
    end else begin
      o_clk_out_oe <= outen_q;
      if (co_cnt_q >= half - 6'h1) begin
        co_cnt_q  <= '0;
        o_clk_out <= ~o_clk_out;
      end else begin
        co_cnt_q <= co_cnt_q + 6'h1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_por_pin_drive: assert property (!supply_s |=> o_ext_reset_oe)
    else $error("reset pin not driven under POR");
  a_dev_pulse_len: assert property ($fell(o_ext_reset_oe)
    |-> $past(drv_cnt_q) == CNT_W'(DEV_PULSE - 1))
    else $error("device reset pulse width wrong");
  a_ext_min_width: assert property ($rose(ext_rec_q)
    |-> $past(ext_low_s, 32))
    else $error("external reset recognised too early");
  a_wdog_pulse_len: assert property ($fell(wd_act_q)
    |-> $past(wd_cnt_q) == CNT_W'(WDOG_CYC - 1))
    else $error("watchdog pulse width wrong");
  a_reset_merge_src: assert property (any_src |=> o_sys_reset)
    else $error("internal reset not held");
  a_addr_valid_dly: assert property ($rose(o_addr_valid)
    |-> $past(state_q) == ST_WAIT && !$past(any_src, 33))
    else $error("address valid delay wrong");
  a_boot_sampled: assert property ($rose(o_boot_valid)
    |-> o_boot_mode == $past(boot_s_q))
    else $error("boot straps not sampled");
  a_lock_twice: assert property ($rose(main_flag_q)
    |-> $past(main_locks_q) == 2'(LOCKS_NEEDED - 1))
    else $error("lock flag before second lock");
  a_clkout_gated: assert property (!outen_q |=> !o_clk_out_oe)
    else $error("clock-out driven while disabled");
  a_clkout_reset: assert property ($rose(supply_s)
    |=> sysdiv_q == SYSDIV_RST && outdiv_q == OUTDIV_RST)
    else $error("clock dividers not at defaults");

  c_wdog_reset: cover property ($fell(wd_act_q));
  c_ext_reset: cover property ($rose(ext_rec_q));
  c_pll_locked: cover property ($rose(main_flag_q));
  c_boot_done: cover property ($rose(o_boot_valid));
endmodule

// *** dv/rcs_partner.sv ***
`timescale 1ns/1ps
module rcs_partner
  import rcs_pkg::*;
#(
  parameter int unsigned HOLD_CYC = 14000,
  parameter bit          REV_ZERO = 1'b0
) (
  input  wire logic                       i_clk_sys,   // System clock
  input  wire logic                       i_sys_reset, // Internal reset
  input  wire logic                       i_supply_up, // Supply control
  input  wire logic                       i_pull_low,  // Supervisor pull
  input  wire logic [rcs_pkg::BOOT_W-1:0] i_strap_val, // Strap setting
  input  wire logic                       i_rst_out,   // Device pin drive
  input  wire logic                       i_rst_oe,    // Device pin enable
  output logic                            o_supply_ok, // Supply good
  output logic                            o_pin_level, // Resolved pin
  output logic [rcs_pkg::BOOT_W-1:0]      o_straps,    // Strap pins
  output logic                            o_osc_ref,   // Main reference
  output logic                            o_aux_ref    // Usb reference
);
  import rcs_pkg::*;
  // ==========================================================
  // Supply, reset pin and straps
  localparam int unsigned HOLD = REV_ZERO ? HOLD_CYC * 23 : HOLD_CYC;
  int unsigned hold_q = 0;

  // Supply follows the bench; pin is open drain with pull-up
  assign o_supply_ok = i_supply_up;
  assign o_pin_level = ~((i_rst_oe & ~i_rst_out) | i_pull_low);

  // Straps held only for the hold window after reset
  always @(posedge i_clk_sys) begin
    if (i_sys_reset) begin
      hold_q <= 0;
    end else if (hold_q < HOLD) begin
      hold_q <= hold_q + 1;
    end
  end
  assign o_straps = (i_sys_reset || hold_q < HOLD) ? i_strap_val
                                                   : ~i_strap_val;

  // ==========================================================
  // Free-running references, 25 MHz main and 50 MHz aux
  initial begin
    o_osc_ref = 1'b0;
    #1;  // Offset keeps reference edges off the sampling clock edge
    forever #20 o_osc_ref = ~o_osc_ref;
  end
  initial begin
    o_aux_ref = 1'b0;
    #1;  // Same offset for the aux reference
    forever #10 o_aux_ref = ~o_aux_ref;
  end
endmodule

// *** dv/reset_and_clock_startup_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module reset_and_clock_startup_sequencer_tb_top;
  import rcs_pkg::*;
  // ==========================================================
  // Signals
  localparam int unsigned DEV_P = 50;
  localparam int unsigned XT_W  = 20;
  logic clk, rst, supply_up, pull_low, bite, ext_out, ext_oe, sys_reset;
  logic supply_ok, pin_level, osc, aux, addr_valid, boot_valid;
  logic clk_out, clk_out_oe;
  logic [BOOT_W-1:0] strap_val, straps, boot_mode;
  rcs_apb_req_t req;
  rcs_apb_rsp_t rsp;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;

  rcs_sequencer #(.DEV_PULSE(DEV_P), .XTAL_WAIT(XT_W)) DUT (
    .i_clk_sys(clk), .i_reset(rst), .i_apb(req), .o_apb(rsp),
    .i_supply_ok(supply_ok), .i_ext_reset_in(pin_level),
    .o_ext_reset_out(ext_out), .o_ext_reset_oe(ext_oe),
    .i_watchdog_bite(bite), .i_boot_pins(straps), .i_osc_ref(osc),
    .i_aux_ref(aux), .o_sys_reset(sys_reset), .o_addr_valid(addr_valid),
    .o_boot_mode(boot_mode), .o_boot_valid(boot_valid),
    .o_clk_out(clk_out), .o_clk_out_oe(clk_out_oe));

  rcs_partner u_partner (
    .i_clk_sys(clk), .i_sys_reset(sys_reset), .i_supply_up(supply_up),
    .i_pull_low(pull_low), .i_strap_val(strap_val), .i_rst_out(ext_out),
    .i_rst_oe(ext_oe), .o_supply_ok(supply_ok), .o_pin_level(pin_level),
    .o_straps(straps), .o_osc_ref(osc), .o_aux_ref(aux));

  // Clock and cycle count
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ==========================================================
  // Helpers
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return ext_oe;
      1: return addr_valid;
      2: return sys_reset;
      3: return clk_out;
      4: return boot_valid;
      default: return pin_level;
    endcase
  endfunction

  // Cycles until a watched output reaches a level
  task automatic wait_for(input int s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("unexpected timeout on signal %0d", s);
      tally_and_finish();
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    // Access edges: pready, data and error taken at the same rising edge
    @(posedge clk);
    n++;
    while (rsp.pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      errors++;
      $display("unexpected pready timeout");
      tally_and_finish();
    end
  endtask

  // Read pll status until masked field matches
  task automatic poll(input logic [31:0] m, input logic [31:0] v,
                      output int t);
    logic [31:0] d;
    logic e;
    int k;
    k = 0;
    d = '0;
    while ((d & m) !== v && k < 8000) begin
      apb(1'b0, ADDR_PLL_STS, 32'h0, d, e);
      k++;
    end
    t = cyc - t0;
    if (k >= 8000) begin
      errors++;
      $display("unexpected lock timeout");
      tally_and_finish();
    end
  endtask

  // Full period of the clock-out pin
  task automatic period(output int p);
    int a;
    int b;
    wait_for(3, 1'b0, 100, a);
    wait_for(3, 1'b1, 100, a);
    wait_for(3, 1'b0, 100, a);
    wait_for(3, 1'b1, 100, b);
    p = a + b;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int n;
    int m;
    logic [31:0] d;
    logic e;
    rst = 1'b1;
    supply_up = 1'b0;
    pull_low = 1'b0;
    bite = 1'b0;
    strap_val = 4'ha;
    req = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t0 = cyc;
    repeat (20) @(posedge clk);
    #1;
    check("pin low drive", {ext_oe, ext_out}, 32'h2);
    check("internal reset", sys_reset, 1'b1);
    @(posedge clk);
    supply_up <= 1'b1;
    #1;
    wait_for(0, 1'b0, 2000, n);
    check("device pulse", n >= DEV_P && n <= DEV_P + 6, 1'b1);
    wait_for(1, 1'b1, 2000, n);
    n = cyc - t0;
    check("startup wait", n >= INTOSC_CYC + XT_W + ADDR_VALID_CYC &&
          n <= INTOSC_CYC + XT_W + DEV_P + ADDR_VALID_CYC + 60,
          1'b1);
    wait_for(4, 1'b1, 10, n);
    check("boot mode", boot_mode, 4'ha);
    apb(1'b0, ADDR_BOOT_STS, 32'h0, d, e);
    check("boot status", d, 32'h1a);
    apb(1'b0, ADDR_CLK_CTRL, 32'h0, d, e);
    check("clock control reset", d, 32'h3);
    check("clock out enable", clk_out_oe, 1'b0);
    apb(1'b1, ADDR_CLK_CTRL, 32'h13, d, e);
    period(n);
    check("clock out enable", clk_out_oe, 1'b1);
    check("clock out period", n, 32'd32);
    apb(1'b1, ADDR_CLK_CTRL, 32'h10, d, e);
    period(n);
    period(n);
    check("clock out period", n, 32'd4);
    apb(1'b0, 8'h10, 32'h0, d, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", d, 32'h0);
    // PLL locks twice on both references
    apb(1'b1, ADDR_PLL_CFG, 32'h3, d, e);
    t0 = cyc;
    poll(32'h30, 32'h10, n);
    check("usb lock time", n >= 4990 && n <= 5040, 1'b1);
    poll(32'h0c, 32'h04, m);
    check("main lock time", m >= 9990 && m <= 10040, 1'b1);
    apb(1'b0, ADDR_PLL_STS, 32'h0, d, e);
    check("flags after one lock", d[1:0], 2'b00);
    apb(1'b1, ADDR_PLL_CFG, 32'h3, d, e);
    t0 = cyc;
    poll(32'h3, 32'h3, n);
    check("second lock time", n >= 9990 && n <= 10040, 1'b1);
    apb(1'b1, ADDR_PLL_CFG, 32'h0, d, e);
    apb(1'b0, ADDR_PLL_STS, 32'h0, d, e);
    check("pll cleared", d, 32'h0);
    // Watchdog pulse
    @(posedge clk);
    bite <= 1'b1;
    @(posedge clk);
    bite <= 1'b0;
    #1;
    wait_for(2, 1'b1, 10, n);
    wait_for(2, 1'b0, 2000, n);
    check("watchdog pulse", n >= WDOG_CYC && n <= WDOG_CYC + 48,
          1'b1);
    // External pulse with new straps
    @(posedge clk);
    strap_val <= 4'h5;
    pull_low <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    check("ext reset", {sys_reset, addr_valid}, 32'h2);
    @(posedge clk);
    pull_low <= 1'b0;
    #1;
    wait_for(5, 1'b1, 2000, n);
    wait_for(1, 1'b1, 200, n);
    check("valid after pin high", n >= ADDR_VALID_CYC &&
          n <= ADDR_VALID_CYC + 5, 1'b1);
    wait_for(4, 1'b1, 10, n);
    check("boot mode", boot_mode, 4'h5);
    tally_and_finish();
  end
endmodule
